// >>> dmio_cfg.svh
/*
 Offsets, field positions, reset values and timing counts of the
 dual-mode digital I/O port. Assumes word-indexed register addresses.
*/
`ifndef DMIO_CFG_SVH
`define DMIO_CFG_SVH
// ----------------------------------------------------------------
// Register offsets (word index, plain register port)
// ----------------------------------------------------------------
`define DMIO_ADDR_W        12
`define DMIO_OFF_MAIN_CTRL 12'h100
`define DMIO_OFF_OUT_VAL   12'h138
`define DMIO_OFF_DIR       12'h139
`define DMIO_OFF_LEVEL     12'h13a
`define DMIO_OFF_FRONT_PH  12'h13c
`define DMIO_OFF_BACK_PH   12'h13d
`define DMIO_OFF_FRONT_AT  12'h13e
`define DMIO_OFF_BACK_AT   12'h13f
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DMIO_MODE_BIT      16
`define DMIO_PHASE_W       12
`define DMIO_ATTEN_W       6
`define DMIO_PHASE_RST     12'h800
`define DMIO_ATTEN_RST     6'h00
// Custom-driver pin layout
`define DMIO_PIN_CLK       0
`define DMIO_PIN_DATA      1
`define DMIO_PIN_LOAD      2
`define DMIO_PIN_SEL_LSB   3
// ----------------------------------------------------------------
// Timing: serial bit half period
// ----------------------------------------------------------------
`define DMIO_CLK_HZ        10000000
`define DMIO_HALF_NS       500
`define DMIO_HALF_CYC      ((`DMIO_HALF_NS*(`DMIO_CLK_HZ/1000000)+999)/1000)
`endif

// >>> dmio_pkg.sv
/*
 Types of the dual-mode digital I/O port.
 Assumes dmio_cfg.svh holds the numbers.
*/
package dmio_pkg;
    // Serial link states
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_LOW,
        SER_HIGH,
        SER_LOAD
    } dmio_ser_t;
    // Which setting a transfer carries
    typedef enum logic [1:0] {
        SEL_FRONT_PH,
        SEL_BACK_PH,
        SEL_FRONT_AT,
        SEL_BACK_AT
    } dmio_sel_t;
endpackage : dmio_pkg

// >>> dmio_sync.sv
/*
 Two-flop synchroniser for the pin levels.
 Assumes pins are asynchronous to clk.
*/
`timescale 1ns/100ps
module dmio_sync #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_syncOut;

    // Next values: stage1 is read only by the second flop
    always_comb begin
        next_stage1  = asyncIn;
        next_syncOut = stage1;
    end

    // Register both stages
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= next_stage1;
            syncOut <= next_syncOut;
        end
    end
endmodule : dmio_sync

// >>> dmio_serial.sv
/*
 Serialiser that shifts one setting out to the front/back-end unit:
 select code on pins, 12 data bits MSB first with a clock, then a load
 pulse. Assumes start only while idle.
*/
`timescale 1ns/100ps
`include "dmio_cfg.svh"
module dmio_serial
    import dmio_pkg::*;
#(
    parameter int HALF_CYC = `DMIO_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Request
    input  wire logic        start,
    input  wire logic [1:0]  sel,
    input  wire logic [11:0] word,
    output logic             busy,
    // Link
    output logic             serClk,
    output logic             serData,
    output logic             serLoad,
    output logic [1:0]       serSel
);
    initial begin
        if (HALF_CYC < 1 || HALF_CYC > 255)
            $error("dmio_serial: HALF_CYC out of range");
    end

    dmio_ser_t   state;
    dmio_ser_t   next_state;
    logic [7:0]  tick;
    logic [7:0]  next_tick;
    logic [3:0]  bitCnt;
    logic [3:0]  next_bitCnt;
    logic [11:0] shift;
    logic [11:0] next_shift;
    logic [1:0]  next_serSel;
    logic        tickDone;

    assign tickDone = (tick == 8'(HALF_CYC - 1));

    // Bit sequencer
    always_comb begin
        next_state  = state;
        next_tick   = tickDone ? 8'h00 : tick + 8'h01;
        next_bitCnt = bitCnt;
        next_shift  = shift;
        next_serSel = serSel;
        case (state)
            SER_IDLE: begin
                next_tick = 8'h00;
                if (start) begin
                    next_state  = SER_LOW;
                    next_shift  = word;
                    next_bitCnt = 4'h0;
                    next_serSel = sel;
                end
            end
            SER_LOW:  if (tickDone) next_state = SER_HIGH;
            SER_HIGH: begin
                if (tickDone) begin
                    next_shift  = {shift[10:0], 1'b0};
                    next_bitCnt = bitCnt + 4'h1;
                    next_state  = (bitCnt == 4'hb) ? SER_LOAD : SER_LOW;
                end
            end
            SER_LOAD: if (tickDone) next_state = SER_IDLE;
            default:  next_state = SER_IDLE;
        endcase
    end

    // Register; outputs straight from flops
    always_ff @(posedge clk) begin
        if (reset) begin
            state   <= SER_IDLE;
            tick    <= 8'h00;
            bitCnt  <= 4'h0;
            shift   <= 12'h000;
            serSel  <= 2'h0;
            serClk  <= 1'b0;
            serData <= 1'b0;
            serLoad <= 1'b0;
            busy    <= 1'b0;
        end else begin
            state   <= next_state;
            tick    <= next_tick;
            bitCnt  <= next_bitCnt;
            shift   <= next_shift;
            serSel  <= next_serSel;
            serClk  <= (next_state == SER_HIGH);
            serData <= next_shift[11];
            serLoad <= (next_state == SER_LOAD);
            busy    <= (next_state != SER_IDLE);
        end
    end

    // A transfer gives exactly twelve clock pulses before the load
    property p_load_after_bits;
        @(posedge clk) disable iff (reset)
        $rose(serLoad) |-> bitCnt == 4'hc;
    endproperty
    a_load_after_bits: assert property (p_load_after_bits) // R8
        else $error("load pulse without twelve bits");
endmodule : dmio_serial

// >>> dmio_port.sv
/*
 Dual-mode 32-bit digital I/O port: generic per-pin driver or custom
 front/back-end unit driver, chosen by the mode bit of main control.
 Assumes a plain register port, read data one cycle after the strobe,
 and asynchronous pins.
*/
// Behaviour
// R1: Mode bit 16 of main control at 0x100 clear selects generic driver.
// R2: Mode bit set selects the custom front/back-end unit driver.
// R3: Generic mode has output value, direction and pin level registers.
// R4: Direction one drives the pin from output value; zero makes input.
// R5: Custom driver exists only from logic revision 1.4 onward.
// R6: Custom mode holds 12-bit offset-binary front and back phase settings.
// R7: Custom mode holds 6-bit front and back attenuation, 0.5 dB steps.
// R8: A written custom setting is shifted out over the port pins.
`timescale 1ns/100ps
`include "dmio_cfg.svh"
module dmio_port
    import dmio_pkg::*;
#(
    parameter int       WIDTH    = 32,
    parameter bit [7:0] REVISION = 8'h14, // Major.minor as hex nibbles
    parameter int       HALF_CYC = `DMIO_HALF_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Register port
    input  wire logic [`DMIO_ADDR_W-1:0] regAddr,
    input  wire logic [31:0]             regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic      [31:0]             regRdData,
    // Pins
    input  wire logic [WIDTH-1:0]        pinIn,
    output logic      [WIDTH-1:0]        pinOut,
    output logic      [WIDTH-1:0]        pinOe
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    initial begin
        if (WIDTH < 6 || WIDTH > 32)
            $error("dmio_port: WIDTH must be 6..32");
    end

    // Custom driver is built only from revision 1.4 onward
    localparam bit HAS_CUSTOM = (REVISION >= 8'h14); // R5

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0]       mainCtrl;
    logic [31:0]       next_mainCtrl;
    logic [WIDTH-1:0]  outVal;
    logic [WIDTH-1:0]  next_outVal;
    logic [WIDTH-1:0]  pinDir;
    logic [WIDTH-1:0]  next_pinDir;
    logic [11:0]       frontPhase;
    logic [11:0]       next_frontPhase;
    logic [11:0]       backPhase;
    logic [11:0]       next_backPhase;
    logic [5:0]        frontAtten;
    logic [5:0]        next_frontAtten;
    logic [5:0]        backAtten;
    logic [5:0]        next_backAtten;
    logic [3:0]        pending;
    logic [3:0]        next_pending;
    logic [31:0]       next_regRdData;
    logic [WIDTH-1:0]  pinLevel;
    logic [WIDTH-1:0]  next_pinOut;
    logic [WIDTH-1:0]  next_pinOe;
    logic              customMode;
    logic              serBusy;
    logic              serStart;
    logic [1:0]        serSelReq;
    logic [11:0]       serWord;
    logic              serClk;
    logic              serData;
    logic              serLoad;
    logic [1:0]        serSel;

    // Mode bit chooses the driver; forced generic without custom logic
    assign customMode = HAS_CUSTOM & mainCtrl[`DMIO_MODE_BIT]; // R1 R2 R5

    // Pad a port-width word to 32 bits, zeroing the upper bits
    function automatic logic [31:0] dmio_pad(input logic [WIDTH-1:0] v);
        logic [31:0] r;
        r = '0;
        r[WIDTH-1:0] = v;
        return r;
    endfunction : dmio_pad

    // Address match for a write
    function automatic logic dmio_hit(input logic [`DMIO_ADDR_W-1:0] a,
                                      input logic [`DMIO_ADDR_W-1:0] o);
        return a == o;
    endfunction : dmio_hit

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    dmio_sync #(
        .WIDTH   (WIDTH)
    ) u_sync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn (pinIn),
        .syncOut (pinLevel)
    );

    // ----------------------------------------------------------------
    // Register writes and pending transfers
    // ----------------------------------------------------------------
    always_comb begin
        next_mainCtrl   = mainCtrl;
        next_outVal     = outVal;
        next_pinDir     = pinDir;
        next_frontPhase = frontPhase;
        next_backPhase  = backPhase;
        next_frontAtten = frontAtten;
        next_backAtten  = backAtten;
        next_pending    = pending;
        // Clear the one being launched first, so a new write re-sets it
        if (serStart)
            next_pending[serSelReq] = 1'b0;
        if (regWr) begin
            if (dmio_hit(regAddr, `DMIO_OFF_MAIN_CTRL))
                next_mainCtrl = regWrData;
            if (dmio_hit(regAddr, `DMIO_OFF_OUT_VAL))
                next_outVal = regWrData[WIDTH-1:0]; // R3
            if (dmio_hit(regAddr, `DMIO_OFF_DIR))
                next_pinDir = regWrData[WIDTH-1:0]; // R3 R4
            if (dmio_hit(regAddr, `DMIO_OFF_FRONT_PH)) begin
                next_frontPhase = regWrData[11:0]; // R6
                next_pending[SEL_FRONT_PH] = 1'b1; // R8
            end
            if (dmio_hit(regAddr, `DMIO_OFF_BACK_PH)) begin
                next_backPhase = regWrData[11:0]; // R6
                next_pending[SEL_BACK_PH] = 1'b1; // R8
            end
            if (dmio_hit(regAddr, `DMIO_OFF_FRONT_AT)) begin
                next_frontAtten = regWrData[5:0]; // R7
                next_pending[SEL_FRONT_AT] = 1'b1; // R8
            end
            if (dmio_hit(regAddr, `DMIO_OFF_BACK_AT)) begin
                next_backAtten = regWrData[5:0]; // R7
                next_pending[SEL_BACK_AT] = 1'b1; // R8
            end
        end
        // Writes without custom logic never queue anything
        if (!HAS_CUSTOM)
            next_pending = 4'h0; // R5
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mainCtrl   <= 32'h0000_0000;
            outVal     <= '0;
            pinDir     <= '0;
            frontPhase <= `DMIO_PHASE_RST;
            backPhase  <= `DMIO_PHASE_RST;
            frontAtten <= `DMIO_ATTEN_RST;
            backAtten  <= `DMIO_ATTEN_RST;
            pending    <= 4'h0;
        end else begin
            mainCtrl   <= next_mainCtrl;
            outVal     <= next_outVal;
            pinDir     <= next_pinDir;
            frontPhase <= next_frontPhase;
            backPhase  <= next_backPhase;
            frontAtten <= next_frontAtten;
            backAtten  <= next_backAtten;
            pending    <= next_pending;
        end
    end

    // ----------------------------------------------------------------
    // Transfer launcher: fixed priority, one setting at a time
    // ----------------------------------------------------------------
    always_comb begin
        serSelReq = SEL_FRONT_PH;
        serWord   = frontPhase;
        if (pending[SEL_FRONT_PH]) begin
            serSelReq = SEL_FRONT_PH;
            serWord   = frontPhase;
        end else if (pending[SEL_BACK_PH]) begin
            serSelReq = SEL_BACK_PH;
            serWord   = backPhase;
        end else if (pending[SEL_FRONT_AT]) begin
            serSelReq = SEL_FRONT_AT;
            serWord   = {6'h00, frontAtten};
        end else begin
            serSelReq = SEL_BACK_AT;
            serWord   = {6'h00, backAtten};
        end
        // Held off in generic mode; queued writes go out on mode entry
        serStart = customMode & !serBusy & (pending != 4'h0); // R8
    end

    dmio_serial #(
        .HALF_CYC (HALF_CYC)
    ) u_serial (
        .clk      (clk),
        .reset    (reset),
        .start    (serStart),
        .sel      (serSelReq),
        .word     (serWord),
        .busy     (serBusy),
        .serClk   (serClk),
        .serData  (serData),
        .serLoad  (serLoad),
        .serSel   (serSel)
    );

    // ----------------------------------------------------------------
    // Pin drivers and read data
    // ----------------------------------------------------------------
    always_comb begin
        // Generic: each direction bit enables its pin from outVal
        next_pinOut = outVal; // R1 R4
        next_pinOe  = pinDir; // R4
        if (customMode) begin
            next_pinOut = '0; // R2
            next_pinOe  = '0;
            next_pinOut[`DMIO_PIN_CLK]  = serClk;
            next_pinOut[`DMIO_PIN_DATA] = serData;
            next_pinOut[`DMIO_PIN_LOAD] = serLoad;
            next_pinOut[`DMIO_PIN_SEL_LSB +: 2] = serSel;
            next_pinOe[`DMIO_PIN_SEL_LSB+1:0] = '1;
        end
        next_regRdData = 32'h0000_0000; // Unmapped reads give zero
        if (regRd) begin
            case (regAddr)
                `DMIO_OFF_MAIN_CTRL: next_regRdData = mainCtrl;
                `DMIO_OFF_OUT_VAL:   next_regRdData = dmio_pad(outVal);
                `DMIO_OFF_DIR:       next_regRdData = dmio_pad(pinDir);
                `DMIO_OFF_LEVEL:     next_regRdData = dmio_pad(pinLevel); // R3
                `DMIO_OFF_FRONT_PH:  next_regRdData = {20'h0, frontPhase};
                `DMIO_OFF_BACK_PH:   next_regRdData = {20'h0, backPhase};
                `DMIO_OFF_FRONT_AT:  next_regRdData = {26'h0, frontAtten};
                `DMIO_OFF_BACK_AT:   next_regRdData = {26'h0, backAtten};
                default:             next_regRdData = 32'h0000_0000;
            endcase
        end
    end

    // Outputs straight from flops; pins float as inputs during reset
    always_ff @(posedge clk) begin
        if (reset) begin
            pinOut    <= '0;
            pinOe     <= '0;
            regRdData <= 32'h0000_0000;
        end else begin
            pinOut    <= next_pinOut;
            pinOe     <= next_pinOe;
            regRdData <= next_regRdData;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_generic_steady;
        !customMode ##1 !customMode;
    endsequence

    property p_generic_drive;
        @(posedge clk) disable iff (reset)
        s_generic_steady |-> pinOe == $past(pinDir)
                             && pinOut == $past(outVal);
    endproperty
    a_generic_drive: assert property (p_generic_drive) // R1
        else $error("generic drive does not follow registers");

    property p_custom_pins;
        @(posedge clk) disable iff (reset)
        customMode ##1 customMode |->
            pinOe[WIDTH-1:`DMIO_PIN_SEL_LSB+2] == '0;
    endproperty
    a_custom_pins: assert property (p_custom_pins) // R2
        else $error("custom mode drives generic pins");

    property p_level_read;
        @(posedge clk) disable iff (reset)
        regRd && regAddr == `DMIO_OFF_LEVEL |=>
            regRdData == dmio_pad($past(pinLevel));
    endproperty
    a_level_read: assert property (p_level_read) // R3
        else $error("level readback wrong");

    property p_input_pins;
        @(posedge clk) disable iff (reset)
        !customMode ##1 !customMode |-> (pinOe & ~$past(pinDir)) == '0;
    endproperty
    a_input_pins: assert property (p_input_pins) // R4
        else $error("input pin driven");

    // Mode bit held set: link pins only when the custom logic is built
    property p_no_custom;
        @(posedge clk) disable iff (reset)
        mainCtrl[`DMIO_MODE_BIT] ##1 mainCtrl[`DMIO_MODE_BIT] |->
            pinOe[`DMIO_PIN_SEL_LSB+1:0] == (HAS_CUSTOM ? 5'h1f
                                              : $past(pinDir[4:0]))
            && (HAS_CUSTOM || pending == 4'h0);
    endproperty
    a_no_custom: assert property (p_no_custom) // R5
        else $error("custom driver active on old revision");

    property p_phase_store;
        @(posedge clk) disable iff (reset)
        regWr && regAddr == `DMIO_OFF_FRONT_PH |=>
            frontPhase == $past(regWrData[11:0]);
    endproperty
    a_phase_store: assert property (p_phase_store) // R6
        else $error("front phase not stored");

    property p_atten_read;
        @(posedge clk) disable iff (reset)
        regRd && regAddr == `DMIO_OFF_BACK_AT |=>
            regRdData[31:6] == 26'h0 && regRdData[5:0] == $past(backAtten);
    endproperty
    a_atten_read: assert property (p_atten_read) // R7
        else $error("back attenuation read wrong");

    property p_write_sends;
        @(posedge clk) disable iff (reset)
        customMode && !serBusy && pending == 4'h0 && regWr
            && regAddr == `DMIO_OFF_BACK_AT |=> ##[1:3] serBusy;
    endproperty
    a_write_sends: assert property (p_write_sends) // R8
        else $error("setting write not transferred");
endmodule : dmio_port

// >>> dmio_unit_model.sv
/*
 Far-side model: the front/back-end unit on the port pins, plus the
 levels that outside equipment puts on undriven pins.
 Assumes the custom link layout and MSB-first serial word.
*/
`timescale 1ns/100ps
module dmio_unit_model (
    // Clock
    input  wire logic        clk,
    // Port pins
    input  wire logic [31:0] pinOut,
    input  wire logic [31:0] pinOe,
    input  wire logic [31:0] extDrive,
    output logic      [31:0] pinLevel,
    // Captured setting
    output logic      [1:0]  lastSel,
    output logic      [11:0] lastWord,
    output int               frames
);
    logic [11:0] shiftReg = 12'h000;
    logic        prevClk  = 1'b0;
    logic        prevLoad = 1'b0;
    logic        link;

    // Undriven pins show the far side, never a stale port value
    assign pinLevel = (pinOut & pinOe) | (extDrive & ~pinOe);
    // Only a fully enabled link may clock the unit
    assign link = &pinOe[4:0];
    initial begin
        frames = 0;
        lastSel = 2'h0;
        lastWord = 12'h000;
    end
    // Shift on rising link clock, latch on rising load
    always @(posedge clk) begin
        if (link && pinLevel[0] && !prevClk) begin
            shiftReg <= {shiftReg[10:0], pinLevel[1]};
        end
        if (link && pinLevel[2] && !prevLoad) begin
            lastSel <= pinLevel[4:3];
            lastWord <= shiftReg;
            frames <= frames + 1;
        end
        prevClk <= pinLevel[0];
        prevLoad <= pinLevel[2];
    end
endmodule : dmio_unit_model

// >>> dual_mode_digital_io_port_test.sv
/*
 Self-checking bench of the dual-mode I/O port with a register model.
 Assumes the plain register port and the unit model on the pins.
*/
`timescale 1ns/100ps
`include "dmio_cfg.svh"
module dual_mode_digital_io_port_test;
    logic        clk;
    logic        reset;
    logic [11:0] regAddr;
    logic [31:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdData;
    logic [31:0] pinOut;
    logic [31:0] pinOe;
    logic [31:0] pinLevel;
    logic [31:0] extDrive;
    logic [1:0]  lastSel;
    logic [11:0] lastWord;
    int          frames;
    int          errors;
    int          comparisons;
    int          seed;
    logic [31:0] mdl [logic [11:0]];
    logic [11:0] addrs [8] = '{12'h100, 12'h138, 12'h139, 12'h13a,
                               12'h13c, 12'h13d, 12'h13e, 12'h13f};

    // ----------------------------------------------------------------
    // Design and far side
    // ----------------------------------------------------------------
    dmio_port #(.HALF_CYC(5)) u_dmio_port (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .pinIn(pinLevel), .pinOut(pinOut),
        .pinOe(pinOe));
    dmio_unit_model u_dmio_unit_model (
        .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
        .pinLevel(pinLevel), .lastSel(lastSel), .lastWord(lastWord),
        .frames(frames));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // ----------------------------------------------------------------
    // Model and bus tasks
    // ----------------------------------------------------------------
    // Implemented width of each address; zero means unmapped
    function automatic logic [31:0] msk(input logic [11:0] a);
        if (a == 12'h13c || a == 12'h13d) return 32'h00000fff;
        if (a == 12'h13e || a == 12'h13f) return 32'h0000003f;
        if (a == 12'h100 || (a >= 12'h138 && a <= 12'h13a))
            return 32'hffffffff;
        return 32'h00000000;
    endfunction : msk

    function automatic logic [31:0] expv(input logic [11:0] a);
        if (a == 12'h13a)
            return (mdl[12'h138] & mdl[12'h139]) | (extDrive & ~mdl[12'h139]);
        return mdl.exists(a) ? mdl[a] : 32'h00000000;
    endfunction : expv

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        // Read-only and unmapped places keep their value
        if (msk(a) != 0 && a != 12'h13a) mdl[a] = d & msk(a);
    endtask : wr

    task automatic chkrd(input logic [11:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check("regRdData", regRdData, expv(a));
    endtask : chkrd

    // Waits a bounded time for the next frame at the unit
    task automatic waitframe(input logic [1:0] s, input logic [11:0] w);
        int n;
        int t;
        n = frames;
        t = 0;
        while (frames == n && t < 400) begin
            @(posedge clk);
            t++;
        end
        #1 check("frames", frames, n + 1);
        check("frameSel", {30'h0, lastSel}, {30'h0, s});
        check("frameWord", {20'h0, lastWord}, {20'h0, w});
    endtask : waitframe

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Watchdog: the sequence needs well under 1 ms
    initial begin
        #5000000;
        errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 91542;
        reset = 1'b1;
        regAddr = 12'h000;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        extDrive = 32'h0;
        foreach (addrs[i]) mdl[addrs[i]] = 32'h0;
        mdl[12'h13c] = 32'h800;
        mdl[12'h13d] = 32'h800;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // Reset values of every register except the pin level
        foreach (addrs[i]) if (i != 3) chkrd(addrs[i]);
        check("pinOe", pinOe, 32'h0);
        // Generic mode: random values, directions and far-side levels
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            extDrive <= $random(seed);
            wr(12'h138, $random(seed));
            wr(12'h139, $random(seed));
            repeat (4) @(posedge clk);
            #1 check("pinOe", pinOe, mdl[12'h139]);
            check("pinOut", pinOut & pinOe, mdl[12'h138] & mdl[12'h139]);
            chkrd(12'h13a);
        end
        // Every place written, read-only and unmapped ones included
        foreach (addrs[i]) wr(addrs[i], $random(seed) & 32'hfffeffff);
        wr(12'h13b, $random(seed));
        wr(12'h0ff, $random(seed));
        foreach (addrs[i]) chkrd(addrs[i]);
        chkrd(12'h13b);
        chkrd(12'h0ff);
        // Custom mode: settle queued transfers, then send each setting
        wr(12'h100, 32'h00010000);
        repeat (800) @(posedge clk);
        #1 check("pinOe", pinOe, 32'h0000001f);
        // Each write lands on an idle link, so it is sent at once
        for (int k = 0; k < 4; k++) begin
            repeat (10) @(posedge clk);
            wr(12'(12'h13c + k), $random(seed));
            waitframe(2'(k), mdl[12'(12'h13c + k)][11:0]);
        end
        // Back-to-back writes queue a second transfer
        wr(12'h13c, $random(seed));
        wr(12'h13f, $random(seed));
        waitframe(2'h0, mdl[12'h13c][11:0]);
        waitframe(2'h3, mdl[12'h13f][11:0]);
        // Back to generic mode
        repeat (200) @(posedge clk);
        wr(12'h100, 32'h0);
        repeat (4) @(posedge clk);
        #1 check("pinOe", pinOe, mdl[12'h139]);
        chkrd(12'h13a);
        results();
    end
endmodule : dual_mode_digital_io_port_test
